// ===== sbs_regs.svh
// Constants of the synchronous burst SRAM: widths, depth, field positions, reset values
`ifndef SBS_REGS_SVH
`define SBS_REGS_SVH
// Word address and data widths
`define SBS_ADDR_W 16
`define SBS_DATA_W 18
// Byte lanes: two lanes of nine bits, lower lane at bit 0, upper lane at bit 9
`define SBS_LANE_W 9
`define SBS_LANES 2
`define SBS_LOW_LANE_LSB 0
`define SBS_HIGH_LANE_LSB 9
// Array depth in words
`define SBS_DEPTH 65536
// Burst counter width, only these low address bits are stepped
`define SBS_CNT_W 2
// Reset values of burst state and output register
`define SBS_CNT_RST 2'h0
`define SBS_BASE_RST 16'h0000
`define SBS_RDATA_RST 9'h000
`endif

// ===== sbs_pkg.sv
// Types shared by the synchronous burst SRAM modules
`include "sbs_regs.svh"
package sbs_pkg;
   typedef logic [`SBS_ADDR_W-1:0] sbs_addr_t;
   typedef logic [`SBS_DATA_W-1:0] sbs_word_t;
   typedef logic [`SBS_CNT_W-1:0] sbs_cnt_t;
   typedef logic [`SBS_LANES-1:0] sbs_lane_t;
   // Access performed in a cycle
   typedef enum logic [1:0] {
      SBS_OP_IDLE = 2'b00,
      SBS_OP_READ = 2'b01,
      SBS_OP_WRITE = 2'b10
   } sbs_op_t;
   // Everything sampled from the pins at a rising edge
   typedef struct packed {
      sbs_addr_t addr;
      sbs_word_t data;
      logic proc_n;
      logic ctrl_n;
      logic adv_n;
      logic ce_n;
      logic lw_n;
      logic hw_n;
   } sbs_in_t;
endpackage : sbs_pkg

// ===== sbs_mem.sv
// Word array with per-lane write enables and a registered read port
`timescale 1ns/1ps
`include "sbs_regs.svh"
module sbs_mem (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Access
   input wire logic rd_en,
   input wire sbs_pkg::sbs_lane_t wr_lane,
   input wire sbs_pkg::sbs_addr_t addr,
   input wire sbs_pkg::sbs_word_t wr_data,
   // Registered read data
   output wire sbs_pkg::sbs_word_t rd_data
);
   import sbs_pkg::*;

   // One array per lane so that each lane has a single writer
   genvar g;
   generate
      for (g = 0; g < `SBS_LANES; g = g + 1) begin : g_lane
         logic [`SBS_LANE_W-1:0] lane_mem [0:`SBS_DEPTH-1];
         logic [`SBS_LANE_W-1:0] lane_rd;
         // Self-timed write: one edge stores the lane, no pulse needed
         always_ff @(posedge clk) begin
            if (wr_lane[g]) begin
               lane_mem[addr] <= wr_data[g*`SBS_LANE_W +: `SBS_LANE_W];
            end
         end
         // Read register holds its word until the next read
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               lane_rd <= `SBS_RDATA_RST;
            end else if (rd_en) begin
               lane_rd <= lane_mem[addr];
            end
         end
         assign rd_data[g*`SBS_LANE_W +: `SBS_LANE_W] = lane_rd;
      end
   endgenerate
endmodule : sbs_mem

// ===== sbs_burst_ctr.sv
// Burst base register and two-bit interleaved burst counter
`timescale 1ns/1ps
`include "sbs_regs.svh"
module sbs_burst_ctr (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic load,
   input wire sbs_pkg::sbs_addr_t load_addr,
   input wire logic step,
   // Address of this cycle's access and current burst state
   output sbs_pkg::sbs_addr_t acc_addr,
   output sbs_pkg::sbs_addr_t base,
   output sbs_pkg::sbs_cnt_t cnt
);
   import sbs_pkg::*;

   sbs_addr_t next_base;
   sbs_cnt_t next_cnt;

   // Step before the access; a two-bit count wraps back to the base by itself
   always_comb begin
      next_base = load ? load_addr : base;
      next_cnt = load ? `SBS_CNT_RST : (step ? cnt + 2'h1 : cnt);
      acc_addr = {next_base[`SBS_ADDR_W-1:`SBS_CNT_W],
                  next_base[`SBS_CNT_W-1:0] ^ next_cnt};
   end

   // Burst state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         base <= `SBS_BASE_RST;
         cnt <= `SBS_CNT_RST;
      end else begin
         base <= next_base;
         cnt <= next_cnt;
      end
   end
endmodule : sbs_burst_ctr

// ===== sbs_sram.sv
// Pipelined synchronous burst SRAM, 64K words of 18 bits, shared data pins
`timescale 1ns/1ps
`include "sbs_regs.svh"
module sbs_sram (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Address and burst control
   input wire sbs_pkg::sbs_addr_t word_addr,
   input wire logic proc_addr_strobe_n,
   input wire logic ctrl_addr_strobe_n,
   input wire logic burst_advance_n,
   input wire logic chip_en_n,
   // Byte write enables
   input wire logic low_byte_wr_n,
   input wire logic high_byte_wr_n,
   // Asynchronous output enable
   input wire logic out_en_n,
   // Shared data pins, split into input, output and enable
   input wire sbs_pkg::sbs_word_t shared_data_pins_in,
   output sbs_pkg::sbs_word_t shared_data_pins_out,
   output logic shared_data_pins_oe
);
   import sbs_pkg::*;

   sbs_in_t cap;
   sbs_word_t write_data_in;
   logic selected;
   logic drive_ok;
   logic wr_any;
   logic load_p;
   logic load_c;
   logic load_any;
   logic desel;
   logic cont;
   logic adv_step;
   sbs_op_t op;
   sbs_addr_t acc_addr;
   sbs_addr_t base;
   sbs_cnt_t cnt;
   logic mem_rd;
   sbs_lane_t mem_lane;
   sbs_word_t mem_rdata;

   // Read or write choice for a cycle that performs an access
   function automatic sbs_op_t pick_op(input logic wr, input logic en);
      if (!en) begin
         return SBS_OP_IDLE;
      end
      return wr ? SBS_OP_WRITE : SBS_OP_READ;
   endfunction : pick_op

   // Input register; reset leaves strobes inactive so nothing starts
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cap <= '1;
      end else begin
         cap.addr <= word_addr;
         cap.data <= shared_data_pins_in;
         cap.proc_n <= proc_addr_strobe_n;
         cap.ctrl_n <= ctrl_addr_strobe_n;
         cap.adv_n <= burst_advance_n;
         cap.ce_n <= chip_en_n;
         cap.lw_n <= low_byte_wr_n;
         cap.hw_n <= high_byte_wr_n;
      end
   end

   assign write_data_in = cap.data;

   // Cycle decode from the registered pins
   always_comb begin
      wr_any = !cap.lw_n || !cap.hw_n;
      // Processor start only counts while enabled, which lets address pipelining work
      load_p = !cap.proc_n && !cap.ce_n;
      load_c = cap.proc_n && !cap.ctrl_n && !cap.ce_n;
      load_any = load_p || load_c;
      desel = !cap.ctrl_n && cap.ce_n;
      // Chip enable plays no part here, a blocked processor strobe falls through
      cont = cap.ctrl_n && !load_p;
      adv_step = cont && !cap.adv_n && selected;
   end

   // Operation of this cycle, priority: processor, controller, deselect, burst
   always_comb begin
      if (load_p) begin
         op = SBS_OP_READ;
      end else if (load_c) begin
         op = pick_op(wr_any, 1'b1);
      end else if (cont) begin
         op = pick_op(wr_any, selected);
      end else begin
         op = SBS_OP_IDLE;
      end
   end

   // Selection survives continue cycles, only a deselect ends it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         selected <= 1'b0;
      end else if (load_any) begin
         selected <= 1'b1;
      end else if (desel) begin
         selected <= 1'b0;
      end
   end

   // Burst addressing
   sbs_burst_ctr u_ctr (
      .clk(clk),
      .rst(rst),
      .load(load_any),
      .load_addr(cap.addr),
      .step(adv_step),
      .acc_addr(acc_addr),
      .base(base),
      .cnt(cnt)
   );

   // Array strobes for the chosen operation
   always_comb begin
      case (op)
         SBS_OP_READ: begin
            mem_rd = 1'b1;
            mem_lane = 2'h0;
         end
         SBS_OP_WRITE: begin
            mem_rd = 1'b0;
            mem_lane = {!cap.hw_n, !cap.lw_n};
         end
         default: begin
            mem_rd = 1'b0;
            mem_lane = 2'h0;
         end
      endcase
   end

   // Array with its read register acting as the output register
   sbs_mem u_mem (
      .clk(clk),
      .rst(rst),
      .rd_en(mem_rd),
      .wr_lane(mem_lane),
      .addr(acc_addr),
      .wr_data(write_data_in),
      .rd_data(mem_rdata)
   );

   assign shared_data_pins_out = mem_rdata;

   // Pins may carry data only in the cycle after a read; writes and deselects float them
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         drive_ok <= 1'b0;
      end else begin
         drive_ok <= (op == SBS_OP_READ);
      end
   end

   // Output enable is a gate, not a register, so it takes effect without a clock.
   // The controller must hold it high around write data or the pins would fight.
   assign shared_data_pins_oe = drive_ok && !out_en_n;

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   load_addr_a: assert property (load_any |-> acc_addr == $past(word_addr))
      else $error("loaded access address differs from sampled pins");

   read_pipe_a: assert property (
      (op == SBS_OP_WRITE && mem_lane == 2'h3) ##1
      (op == SBS_OP_READ && acc_addr == $past(acc_addr))
      |=> shared_data_pins_out == $past(write_data_in, 2))
      else $error("read after write did not return written word");

   oe_float_a: assert property (out_en_n || !drive_ok |-> !shared_data_pins_oe)
      else $error("pins driven while disabled or not reading");

   byte_lane_a: assert property (
      op == SBS_OP_WRITE |-> mem_lane == {!cap.hw_n, !cap.lw_n} && mem_lane != 2'h0)
      else $error("write lanes do not follow byte enables");

   proc_read_a: assert property (
      !cap.proc_n && !cap.ce_n |-> op == SBS_OP_READ && acc_addr == cap.addr && mem_lane == 2'h0)
      else $error("processor start did not read new address");

   ctrl_load_a: assert property (
      load_c |-> acc_addr == cap.addr && op == (wr_any ? SBS_OP_WRITE : SBS_OP_READ))
      else $error("controller start wrong address or direction");

   desel_float_a: assert property (desel |=> !selected && !shared_data_pins_oe)
      else $error("deselect left device driving or selected");

   ce_ignored_a: assert property (
      cont && selected && cap.ce_n |-> op != SBS_OP_IDLE)
      else $error("chip enable stopped a burst cycle");

   adv_step_a: assert property (
      adv_step |-> acc_addr[1:0] == (base[1:0] ^ (cnt + 2'h1)))
      else $error("advance did not step the low bits");

   suspend_hold_a: assert property (
      cont && selected && cap.adv_n |-> acc_addr == $past(acc_addr))
      else $error("suspend changed the address");

   upper_hold_a: assert property (
      cont && selected |-> acc_addr[15:2] == base[15:2])
      else $error("burst changed upper address bits");

   burst_wrap_a: assert property (
      load_any ##1 adv_step [*4] |-> acc_addr == $past(acc_addr, 4))
      else $error("burst did not wrap to base after four");

   burst_dir_a: assert property (
      cont && selected |-> op == (wr_any ? SBS_OP_WRITE : SBS_OP_READ))
      else $error("burst cycle chose wrong direction");

   interleave_a: assert property (
      load_any ##1 adv_step |-> acc_addr[1:0] == ($past(acc_addr[1:0]) ^ 2'h1))
      else $error("second burst address not interleaved");

   // Check-side burst position, rebuilt from the strobes and the loaded low bits only
   logic [1:0] chk_lo;
   logic [1:0] chk_pos;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         chk_lo <= 2'h0;
         chk_pos <= 2'h0;
      end else if (load_any) begin
         chk_lo <= cap.addr[1:0];
         chk_pos <= 2'h0;
      end else if (adv_step) begin
         chk_pos <= chk_pos + 2'h1; // Two bits, so it wraps after the fourth address
      end
   end

   burst_order_a: assert property (
      adv_step |-> acc_addr[1:0] == (chk_lo ^ (chk_pos + 2'h1)))
      else $error("burst address left the interleaved order");

   // Output register and pin checks
   out_hold_a: assert property (
      op != SBS_OP_READ |=> $stable(shared_data_pins_out))
      else $error("read data changed without a read");

   write_float_a: assert property (
      op != SBS_OP_READ |=> !shared_data_pins_oe)
      else $error("pins driven after a cycle without a read");

   oe_drive_a: assert property (
      op == SBS_OP_READ ##1 !out_en_n |-> shared_data_pins_oe)
      else $error("pins not driven for a read with output enable low");

   // Lane checks: a write followed by a read of the same word returns the written lane
   low_lane_a: assert property (
      (op == SBS_OP_WRITE && mem_lane[0]) ##1
      (op == SBS_OP_READ && acc_addr == $past(acc_addr))
      |=> ((shared_data_pins_out ^ $past(write_data_in, 2)) & 18'h001FF) == 18'h00000)
      else $error("lower lane did not keep its written bits");

   high_lane_a: assert property (
      (op == SBS_OP_WRITE && mem_lane[1]) ##1
      (op == SBS_OP_READ && acc_addr == $past(acc_addr))
      |=> ((shared_data_pins_out ^ $past(write_data_in, 2)) & 18'h3FE00) == 18'h00000)
      else $error("upper lane did not keep its written bits");

   // Deselect and blocked strobe checks
   desel_idle_a: assert property (desel |-> op == SBS_OP_IDLE && mem_lane == 2'h0)
      else $error("deselect cycle performed an access");

   proc_block_a: assert property (
      !cap.proc_n && cap.ce_n |-> !load_any && acc_addr[15:2] == base[15:2])
      else $error("blocked processor strobe loaded an address");

   unsel_quiet_a: assert property (
      !selected && cont |-> op == SBS_OP_IDLE && !adv_step)
      else $error("burst cycle acted while deselected");

   // Main scenarios
   two_cycle_wr_c: cover property (load_p ##1 (cont && op == SBS_OP_WRITE));
   full_burst_c: cover property (load_c ##1 adv_step [*3]);
   wait_state_c: cover property (load_any ##1 (cont && cap.adv_n) ##1 adv_step);
   deselect_c: cover property (selected && desel);
   unsel_burst_c: cover property (!selected && cont && !cap.adv_n);
endmodule : sbs_sram

// ===== sbs_ctrl_model.sv
// Bus controller model driving the burst SRAM pins one cycle at a time
`timescale 1ns/1ps
module sbs_ctrl_model (
   // Clock
   input wire logic clk,
   // Address and control pins
   output sbs_pkg::sbs_addr_t word_addr,
   output logic proc_addr_strobe_n,
   output logic ctrl_addr_strobe_n,
   output logic burst_advance_n,
   output logic chip_en_n,
   output logic low_byte_wr_n,
   output logic high_byte_wr_n,
   output logic out_en_n,
   // Controller side of the shared data pins
   output sbs_pkg::sbs_word_t data_drv,
   output logic data_en
);
   import sbs_pkg::*;
   // Quiet pins at time zero, output enable high so nobody drives
   initial begin
      {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n, chip_en_n} = 4'hF;
      {low_byte_wr_n, high_byte_wr_n, out_en_n} = 3'h7;
      word_addr = 16'h0000;
      data_drv = 18'h00000;
      data_en = 1'b0;
   end
   // One cycle {oe_n,proc_n,ctrl_n,adv_n,ce_n,lw_n,hw_n}, launched at the falling edge
   task automatic cyc(input sbs_addr_t a, input sbs_word_t d, input logic [6:0] ctl);
      @(negedge clk);
      word_addr = a;
      {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} = ctl[5:3];
      {chip_en_n, low_byte_wr_n, high_byte_wr_n} = ctl[2:0];
      data_en = ~(ctl[1] & ctl[0]);
      // Released data toggles each cycle so a stale copy can never pass as written data
      data_drv = data_en ? d : ~data_drv;
      // Output enable stays high over every write cycle, so the pins never fight
      out_en_n = ctl[6] | data_en;
   endtask : cyc
endmodule : sbs_ctrl_model

// ===== testbench.sv
// Self-checking testbench of the burst SRAM against the controller model
`timescale 1ns/1ps
module testbench;
   import sbs_pkg::*;
   // Patterns {oe_n,proc_n,ctrl_n,adv_n,ce_n,lw_n,hw_n}
   localparam logic [6:0] p_rd = 7'h1B, p_rdw = 7'h18, p_dis = 7'h1F, c_wr = 7'h28;
   localparam logic [6:0] c_rd = 7'h2B, lo_wr = 7'h29, hi_wr = 7'h2A, desel = 7'h2F;
   localparam logic [6:0] cont_rd = 7'h37, cont_wr = 7'h34, susp_rd = 7'h3F;
   localparam logic [6:0] susp_wr = 7'h3C, g_hi = 7'h40;
   logic clk = 1'b0;
   logic rst = 1'b1;
   sbs_addr_t addr;
   logic ps_n, cs_n, adv_n, ce_n, lw_n, hw_n, g_n, dut_oe, data_en;
   sbs_word_t pins, dut_out, drv;
   int num_errors = 0;
   int n_tests = 0;
   logic ev [2] = '{1'b0, 1'b0};
   sbs_word_t ed [2];
   // Resolved shared pins: the device wins only while it drives
   assign pins = dut_oe ? dut_out : drv;
   always #2.5 clk = ~clk;
   sbs_sram u_sbs_sram (.clk(clk), .rst(rst), .word_addr(addr), .proc_addr_strobe_n(ps_n),
      .ctrl_addr_strobe_n(cs_n), .burst_advance_n(adv_n), .chip_en_n(ce_n),
      .low_byte_wr_n(lw_n), .high_byte_wr_n(hw_n), .out_en_n(g_n),
      .shared_data_pins_in(pins), .shared_data_pins_out(dut_out),
      .shared_data_pins_oe(dut_oe));
   sbs_ctrl_model u_sbs_ctrl_model (.clk(clk), .word_addr(addr), .proc_addr_strobe_n(ps_n),
      .ctrl_addr_strobe_n(cs_n), .burst_advance_n(adv_n), .chip_en_n(ce_n),
      .low_byte_wr_n(lw_n), .high_byte_wr_n(hw_n), .out_en_n(g_n),
      .data_drv(drv), .data_en(data_en));
   task automatic cmp(input sbs_word_t got, input sbs_word_t exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   // One cycle; judges the read launched two cycles earlier, as the input and output registers delay it
   task automatic op(input sbs_addr_t a, input sbs_word_t d, input logic [6:0] ctl,
                     input logic chk, input sbs_word_t e);
      logic c0;
      sbs_word_t e0;
      c0 = ev[0];
      e0 = ed[0];
      ev[0] = ev[1];
      ed[0] = ed[1];
      ev[1] = chk;
      ed[1] = e;
      u_sbs_ctrl_model.cyc(a, d, ctl);
      #1;
      cmp({17'h0, dut_oe}, {17'h0, c0 & ~ctl[6] & ctl[1] & ctl[0]});
      if (c0) cmp(dut_out, e0);
   endtask : op
   task automatic flush;
      op(16'h0000, 18'h00000, desel, 1'b0, 18'h00000);
      op(16'h0000, 18'h00000, desel, 1'b0, 18'h00000);
   endtask : flush
   task automatic t_basic;
      op(16'hFFFF, 18'h2A5A5, c_wr, 1'b0, 18'h0);
      op(16'h0000, 18'h15A5A, c_wr, 1'b0, 18'h0);
      op(16'hFFFF, 18'h0, p_rd, 1'b1, 18'h2A5A5);
      op(16'h0000, 18'h0, c_rd, 1'b1, 18'h15A5A);
      op(16'h0000, 18'h0, desel | g_hi, 1'b0, 18'h0);
      op(16'h0000, 18'h0, desel, 1'b0, 18'h0);
      $display("test basic done");
   endtask : t_basic
   task automatic t_lanes;
      op(16'h0100, 18'h3FFFF, c_wr, 1'b0, 18'h0);
      op(16'h0100, 18'h00000, lo_wr, 1'b0, 18'h0);
      op(16'h0100, 18'h15555, hi_wr, 1'b0, 18'h0);
      op(16'h0100, 18'h0, c_rd, 1'b1, 18'h15400);
      flush();
      $display("test lanes done");
   endtask : t_lanes
   task automatic t_two_cycle;
      op(16'h0200, 18'h0AAAA, c_wr, 1'b0, 18'h0);
      op(16'h0200, 18'h11111, p_rdw, 1'b1, 18'h0AAAA);
      op(16'h0F0F, 18'h2BBBB, susp_wr, 1'b0, 18'h0);
      op(16'h0200, 18'h0, p_rd, 1'b1, 18'h2BBBB);
      flush();
      $display("test two cycle write done");
   endtask : t_two_cycle
   task automatic t_burst;
      op(16'h1236, 18'h0F00F, c_wr, 1'b0, 18'h0);
      op(16'h0F0F, 18'h30C30, cont_wr, 1'b0, 18'h0);
      op(16'h0F0F, 18'h12345, cont_wr, 1'b0, 18'h0);
      op(16'h0F0F, 18'h2ABCD, cont_wr, 1'b0, 18'h0);
      op(16'h0F0F, 18'h3C3C3, cont_wr, 1'b0, 18'h0);
      op(16'h1235, 18'h0, p_rd, 1'b1, 18'h2ABCD);
      op(16'h0F0F, 18'h0, susp_rd, 1'b1, 18'h2ABCD);
      op(16'h0F0F, 18'h0, cont_rd, 1'b1, 18'h12345);
      op(16'h0F0F, 18'h0, cont_rd, 1'b1, 18'h30C30);
      op(16'h0F0F, 18'h0, cont_rd, 1'b1, 18'h3C3C3);
      op(16'h0F0F, 18'h0, cont_rd, 1'b1, 18'h2ABCD);
      flush();
      $display("test burst done");
   endtask : t_burst
   task automatic t_deselect;
      op(16'h1235, 18'h0, p_rd, 1'b1, 18'h2ABCD);
      op(16'h1235, 18'h0, desel, 1'b0, 18'h0);
      op(16'h0000, 18'h0, p_dis, 1'b0, 18'h0);
      op(16'h0F0F, 18'h0, cont_rd, 1'b0, 18'h0);
      flush();
      $display("test deselect done");
   endtask : t_deselect
   task automatic end_of_test;
      $display("checks=%0d errors=%0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test
   // Main sequence: reset, then each scenario in turn
   initial begin
      repeat (5) @(posedge clk);
      @(negedge clk);
      cmp({17'h0, dut_oe}, 18'h00000);
      rst = 1'b0;
      t_basic();
      t_lanes();
      t_two_cycle();
      t_burst();
      t_deselect();
      end_of_test();
   end
   // Watchdog: the scenarios need well under a microsecond
   initial begin
      #5000;
      num_errors++;
      end_of_test();
   end
endmodule : testbench
